// ==== rtl/usf_pkg.sv ====
package usf_pkg;
  // register offsets on the three address pins
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_IER  = 3'h1;
  localparam logic [2:0] OFS_FCR  = 3'h2;
  localparam logic [2:0] OFS_LCR  = 3'h3;
  localparam logic [2:0] OFS_MCR  = 3'h4;
  localparam logic [2:0] OFS_LSR  = 3'h5;
  localparam logic [2:0] OFS_MSR  = 3'h6;
  localparam logic [2:0] OFS_SPR  = 3'h7;
  localparam logic [2:0] OFS_DLL  = 3'h0;
  localparam logic [2:0] OFS_DLM  = 3'h1;
  localparam logic [2:0] OFS_DLD  = 3'h2;
  localparam logic [2:0] OFS_EFR  = 3'h2;
  // line control value that opens the enhanced feature register
  localparam logic [7:0] LCR_EFR_KEY = 8'hbf;
  // field positions
  localparam int LCR_DLAB = 7;
  localparam int MCR_LOOP = 4;
  localparam int MCR_PRESC = 7;
  localparam int IER_MSI  = 3;
  localparam int FCR_FIFO = 0;
  localparam int EFR_ENH  = 4;
  localparam int EFR_ACTS = 7;
  localparam int DLD_SR4  = 5;
  localparam int DLD_SR8  = 4;
  localparam int DLD_FRAC_W = 4;
  // enhanced bits, writable only while the enable is set
  localparam logic [7:0] IER_ENH_MASK = 8'hf0;
  localparam logic [7:0] FCR_ENH_MASK = 8'h30;
  localparam logic [7:0] MCR_ENH_MASK = 8'he0;
  localparam logic [7:0] DLD_WR_MASK  = 8'h3f;
  // reset values
  localparam logic [7:0] SPR_RST = 8'hff;
  localparam logic [7:0] DLL_RST = 8'h01;
  localparam logic [7:0] DLM_RST = 8'h00;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [3:0] PINS_IDLE = 4'hf;
  localparam int ERR_CNT_W = 6;

  typedef enum logic [1:0] {SR_16X = 2'h0, SR_8X = 2'h1, SR_4X = 2'h2} usf_srate_t;
  typedef enum logic [1:0] {
    TXF_NONE = 2'h0, TXF_PAIR1 = 2'h1, TXF_PAIR2 = 2'h2, TXF_DUAL = 2'h3
  } usf_txfc_t;
  typedef enum logic [2:0] {
    RXF_NONE = 3'h0, RXF_PAIR1 = 3'h1, RXF_PAIR2 = 3'h2, RXF_EITHER = 3'h3, RXF_DUAL = 3'h4
  } usf_rxfc_t;

  // modem inputs in status bit order: cts lowest, cd highest
  typedef struct packed {
    logic cd;
    logic ri;
    logic dsr;
    logic cts;
  } usf_modem_t;

  typedef struct packed {
    usf_txfc_t tx_mode;
    usf_rxfc_t rx_mode;
    logic      tx_dual;
    logic      rx_dual;
  } usf_flow_t;

  typedef struct packed {
    logic [15:0]           integer_part;
    logic [DLD_FRAC_W-1:0] fraction;
    usf_srate_t            srate;
    logic                  prescale4;
  } usf_baud_t;
endpackage

// ==== rtl/usf_flow_decode.sv ====
module usf_flow_decode
  import usf_pkg::*;
(
  input  wire logic [3:0] efr_ctl_in, // software flow select bits
  output usf_flow_t       flow_out    // decoded transmit and receive modes
);
  wire logic [1:0] tx_bits = efr_ctl_in[3:2];
  wire logic [1:0] rx_bits = efr_ctl_in[1:0];
  usf_txfc_t tx_mode;
  usf_rxfc_t rx_mode;

  // transmit bit 3 picks the first pair, bit 2 the second
  assign tx_mode = (tx_bits == 2'h3) ? TXF_DUAL :  // [R13]
                   (tx_bits == 2'h2) ? TXF_PAIR1 :
                   (tx_bits == 2'h1) ? TXF_PAIR2 : TXF_NONE;

  // with both receive bits set, single or dual matching depends on transmit
  assign rx_mode = (rx_bits == 2'h2) ? RXF_PAIR1 :  // [R14]
                   (rx_bits == 2'h1) ? RXF_PAIR2 :
                   (rx_bits == 2'h0) ? RXF_NONE :
                   (tx_bits == 2'h1 || tx_bits == 2'h2) ? RXF_EITHER : RXF_DUAL; // [R15]

  assign flow_out.tx_mode = tx_mode;
  assign flow_out.rx_mode = rx_mode;
  assign flow_out.tx_dual = (tx_mode == TXF_DUAL); // [R16]
  assign flow_out.rx_dual = (rx_mode == RXF_DUAL); // [R16]
endmodule

// ==== rtl/usf_regs.sv ====
// What this block and the host software do
// R1 - transmitter-empty reads 1 only when holding/FIFO and shifter are empty
// R2 - error-sum flag is 1 while any FIFO byte carries an error tag
// R3 - cts, dsr and cd change flags set on any change since last read
// R4 - ring change flag sets only on ring input low to high
// R5 - any change flag with modem interrupt enabled raises the interrupt
// R6 - auto cts: high input halts transmit after current character
// R7 - upper modem status bits show inverted cts, dsr, ri, cd inputs
// R8 - in loopback upper status bits come from modem control bits
// R9 - eight-bit scratch register, read/write, resets to all ones
// R10 - divisor is high byte over low byte plus fraction over sixteen
// R11 - fraction register writes only work while enhanced enable is set
// R12 - fraction bits 5:4 pick 16x, 8x or 4x sampling
// R13 - transmit flow mode follows feature bits 3 and 2
// R14 - receive matching follows feature bits 1 and 0
// R15 - receive 11 matches either pair or dual sequence by transmit bits
// R16 - dual modes treat the two on or off characters as one sequence
// R17 - software clears flow select bits before choosing a new setting
// R18 - enhanced bits are writable only while enhanced enable is set
// R19 - reset clears enhanced bits, fraction register and enhanced enable
// R20 - loopback is active while modem control bit 4 is set
// R21 - fraction register bits 7 and 6 read zero, ignore writes
module usf_regs
  import usf_pkg::*;
(
  input  wire logic        ref_clk_in,        // 200 MHz device clock
  input  wire logic        reset_in,          // synchronous, active high
  input  wire logic        cs_n_in,           // chip select pin, active low
  input  wire logic        ior_n_in,          // read strobe pin, active low
  input  wire logic        iow_n_in,          // write strobe pin, active low
  input  wire logic [2:0]  addr_in,           // register address pins
  input  wire logic [7:0]  data_in,           // data bus, pin level
  output logic      [7:0]  data_out,          // data bus, driven value
  output logic             data_oe_out,       // high while driving data bus
  input  wire usf_modem_t  modem_n_in,        // modem input pins, active low
  input  wire logic [7:0]  rx_data_in,        // receive holding byte
  input  wire logic [7:0]  isr_in,            // interrupt status from engine
  input  wire logic [5:0]  lsr_low_in,        // line status bits 5..0
  input  wire logic        tx_fifo_empty_in,  // transmit fifo empty
  input  wire logic        tx_holding_empty_in, // holding register empty
  input  wire logic        tx_shift_empty_in, // transmit shifter empty
  input  wire logic        rx_push_in,        // byte written into rx fifo
  input  wire logic        rx_push_err_in,    // that byte has an error tag
  input  wire logic        rx_pop_in,         // byte read out of rx fifo
  input  wire logic        rx_pop_err_in,     // that byte had an error tag
  output usf_baud_t        divisor_out,       // divisor, fraction, rate
  output usf_flow_t        flow_out,          // software flow modes
  output logic             tx_pause_out,      // auto cts halt of transmit
  output logic             modem_irq_out,     // modem status interrupt
  output logic      [7:0]  ier_out,           // interrupt enable value
  output logic      [7:0]  fcr_out,           // fifo control value
  output logic      [7:0]  lcr_out,           // line control value
  output logic      [7:0]  mcr_out,           // modem control value
  output logic             thr_wr_out,        // pulse: tx holding write
  output logic             fcr_wr_out,        // pulse: fifo control write
  output logic      [7:0]  wr_data_out,       // data of the write pulses
  output logic             rhr_rd_out         // pulse: rx holding read
);

  function automatic logic [7:0] enh_merge(input logic [7:0] old_v,
                                           input logic [7:0] new_v,
                                           input logic [7:0] mask,
                                           input logic       en);
    enh_merge = en ? new_v : ((new_v & ~mask) | (old_v & mask));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; stage one feeds only stage two
  logic [2:0] strb_s1, strb_s2;
  logic [2:0] addr_s1, addr_s2;
  logic [7:0] data_s1, data_s2;
  logic [3:0] modem_s1, modem_s2;

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      strb_s1  <= 3'h7;
      strb_s2  <= 3'h7;
    end else begin
      strb_s1  <= {cs_n_in, ior_n_in, iow_n_in};
      strb_s2  <= strb_s1;
    end
  end

  // modem syncs track the pins through reset, so a pin that is not idle at
  // release is not mistaken for a change
  always_ff @(posedge ref_clk_in) begin
    modem_s1 <= modem_n_in;
    modem_s2 <= modem_s1;
    addr_s1 <= addr_in;
    addr_s2 <= addr_s1;
    data_s1 <= data_in;
    data_s2 <= data_s1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus strobes: read acts at its start, write at its end
  logic       rd_act_q, wr_act_q;
  logic [2:0] wr_addr;
  logic [7:0] wr_data;
  wire logic  rd_act = ~strb_s2[2] & ~strb_s2[1];
  wire logic  wr_act = ~strb_s2[2] & ~strb_s2[0];
  wire logic  rd_stb = rd_act & ~rd_act_q;
  wire logic  wr_stb = wr_act_q & ~wr_act;

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      rd_act_q <= 1'h0;
      wr_act_q <= 1'h0;
      wr_addr  <= 3'h0;
      wr_data  <= REG_RST;
    end else begin
      rd_act_q <= rd_act;
      wr_act_q <= wr_act;
      if (wr_act) begin
        wr_addr <= addr_s2;
        wr_data <= data_s2;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] interrupt_enable, fifo_control, lcr, modem_control, scratch_pad, dll, divisor_high, divisor_fraction_sampling, enhanced_feature;
  wire logic  dlab    = lcr[LCR_DLAB];
  wire logic  efr_sel = (lcr == LCR_EFR_KEY);
  wire logic  enh_en  = enhanced_feature[EFR_ENH];
  wire logic  loop_en = modem_control[MCR_LOOP]; // [R20]

  wire logic we_dll = wr_stb && dlab && (wr_addr == OFS_DLL);
  wire logic we_dlm = wr_stb && dlab && (wr_addr == OFS_DLM);
  wire logic we_dld = wr_stb && dlab && !efr_sel && (wr_addr == OFS_DLD);
  wire logic we_efr = wr_stb && efr_sel && (wr_addr == OFS_EFR);
  wire logic we_thr = wr_stb && !dlab && (wr_addr == OFS_DATA);
  wire logic we_ier = wr_stb && !dlab && (wr_addr == OFS_IER);
  wire logic we_fcr = wr_stb && !dlab && (wr_addr == OFS_FCR);
  wire logic we_lcr = wr_stb && (wr_addr == OFS_LCR);
  wire logic we_mcr = wr_stb && (wr_addr == OFS_MCR);
  wire logic we_spr = wr_stb && (wr_addr == OFS_SPR);

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      interrupt_enable <= REG_RST; // [R19]
      fifo_control <= REG_RST; // [R19]
      lcr <= REG_RST;
      modem_control <= REG_RST; // [R19]
      enhanced_feature <= REG_RST; // [R19]
      divisor_fraction_sampling <= REG_RST; // [R19]
      scratch_pad <= SPR_RST; // [R9]
      dll <= DLL_RST;
      divisor_high <= DLM_RST;
    end else begin
      if (we_ier) interrupt_enable <= enh_merge(interrupt_enable, wr_data, IER_ENH_MASK, enh_en); // [R18]
      if (we_fcr) fifo_control <= enh_merge(fifo_control, wr_data, FCR_ENH_MASK, enh_en); // [R18]
      if (we_mcr) modem_control <= enh_merge(modem_control, wr_data, MCR_ENH_MASK, enh_en); // [R18]
      if (we_dld && enh_en) divisor_fraction_sampling <= wr_data & DLD_WR_MASK; // [R11] [R21]
      if (we_lcr) lcr <= wr_data;
      if (we_efr) enhanced_feature <= wr_data;
      if (we_spr) scratch_pad <= wr_data; // [R9]
      if (we_dll) dll <= wr_data;
      if (we_dlm) divisor_high <= wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // modem status: effective active-low levels, pins or loopback
  logic [3:0] eff_prev, delta;
  logic       eff_valid;
  wire logic [3:0] loop_pins = ~{modem_control[3], modem_control[2], modem_control[0], modem_control[1]};
  wire logic [3:0] eff_pin   = loop_en ? loop_pins : modem_s2; // [R8]
  wire logic [3:0] msr_hi    = ~eff_pin; // [R7]
  wire logic       msr_rd    = rd_stb && (addr_s2 == OFS_MSR);
  wire logic [3:0] delta_set;

  assign delta_set[0] = eff_valid && (eff_pin[0] != eff_prev[0]); // [R3]
  assign delta_set[1] = eff_valid && (eff_pin[1] != eff_prev[1]); // [R3]
  assign delta_set[2] = eff_valid && !eff_prev[2] && eff_pin[2];  // [R4]
  assign delta_set[3] = eff_valid && (eff_pin[3] != eff_prev[3]); // [R3]

  // a change in the read cycle survives the clear
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      eff_prev  <= PINS_IDLE;
      eff_valid <= 1'h0;
      delta     <= 4'h0;
    end else begin
      eff_prev  <= eff_pin;
      eff_valid <= 1'h1;
      delta     <= (msr_rd ? 4'h0 : delta) | delta_set;
    end
  end

  assign modem_irq_out = (|delta) && interrupt_enable[IER_MSI]; // [R5]

  ////////////////////////////////////////////////////////////////////////////
  // line status flags
  logic                 temt;
  logic [ERR_CNT_W-1:0] err_cnt;
  wire logic fifo_mode = fifo_control[FCR_FIFO];
  wire logic next_temt = tx_shift_empty_in &&
                         (fifo_mode ? tx_fifo_empty_in : tx_holding_empty_in); // [R1]
  wire logic err_in    = rx_push_in && rx_push_err_in;
  wire logic err_out   = rx_pop_in && rx_pop_err_in;
  wire logic [7:0] lsr_val = {(err_cnt != '0), temt, lsr_low_in}; // [R2]

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      temt    <= 1'h1;
      err_cnt <= '0;
    end else begin
      temt <= next_temt; // [R1]
      if (err_in && !err_out) begin
        err_cnt <= err_cnt + ERR_CNT_W'(1); // [R2]
      end else if (err_out && !err_in && err_cnt != '0) begin
        err_cnt <= err_cnt - ERR_CNT_W'(1); // [R2]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // auto cts: stop only on a character boundary, resume at once
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      tx_pause_out <= 1'h0;
    end else if (!enhanced_feature[EFR_ACTS] || !eff_pin[0]) begin
      tx_pause_out <= 1'h0; // [R6]
    end else if (tx_shift_empty_in) begin
      tx_pause_out <= 1'h1; // [R6]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data mux
  logic [7:0] rd_mux;
  always_comb begin
    if (addr_s2 == OFS_DATA) begin
      rd_mux = dlab ? dll : rx_data_in;
    end else if (addr_s2 == OFS_IER) begin
      rd_mux = dlab ? divisor_high : interrupt_enable;
    end else if (addr_s2 == OFS_FCR) begin
      rd_mux = efr_sel ? enhanced_feature : (dlab ? divisor_fraction_sampling : isr_in); // [R21]
    end else if (addr_s2 == OFS_LCR) begin
      rd_mux = lcr;
    end else if (addr_s2 == OFS_MCR) begin
      rd_mux = modem_control;
    end else if (addr_s2 == OFS_LSR) begin
      rd_mux = lsr_val;
    end else if (addr_s2 == OFS_MSR) begin
      rd_mux = {msr_hi, delta};
    end else begin
      rd_mux = scratch_pad;
    end
  end

  // snapshot at read start so the host sees a stable byte
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      data_out    <= REG_RST;
      rhr_rd_out  <= 1'h0;
      thr_wr_out  <= 1'h0;
      fcr_wr_out  <= 1'h0;
      wr_data_out <= REG_RST;
    end else begin
      if (rd_stb) data_out <= rd_mux;
      rhr_rd_out  <= rd_stb && !dlab && (addr_s2 == OFS_DATA);
      thr_wr_out  <= we_thr;
      fcr_wr_out  <= we_fcr;
      wr_data_out <= wr_data;
    end
  end

  assign data_oe_out = rd_act;

  ////////////////////////////////////////////////////////////////////////////
  // configuration outputs
  usf_flow_t flow_dec;
  usf_flow_decode u_flow (
    .efr_ctl_in (enhanced_feature[3:0]),
    .flow_out   (flow_dec)
  );

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      divisor_out <= '0;
      flow_out    <= '0;
    end else begin
      divisor_out.integer_part <= {divisor_high, dll}; // [R10]
      divisor_out.fraction     <= divisor_fraction_sampling[DLD_FRAC_W-1:0]; // [R10]
      divisor_out.srate        <= divisor_fraction_sampling[DLD_SR4] ? SR_4X :
                                  divisor_fraction_sampling[DLD_SR8] ? SR_8X : SR_16X; // [R12]
      divisor_out.prescale4    <= modem_control[MCR_PRESC];
      flow_out                 <= flow_dec; // [R13] [R14]
    end
  end

  assign ier_out = interrupt_enable;
  assign fcr_out = fifo_control;
  assign lcr_out = lcr;
  assign mcr_out = modem_control;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_temt;
    @(posedge ref_clk_in) disable iff (reset_in)
      (fifo_mode && !tx_fifo_empty_in) |=> !lsr_val[6];
  endproperty
  a_temt: assert property (p_temt) else $error("temt set with fifo data"); // [R1]

  property p_err_sum;
    @(posedge ref_clk_in) disable iff (reset_in)
      (err_in && !err_out) |=> lsr_val[7];
  endproperty
  a_err_sum: assert property (p_err_sum) else $error("error sum missed"); // [R2]

  property p_delta_chg;
    @(posedge ref_clk_in) disable iff (reset_in)
      (eff_valid && (eff_pin[0] != eff_prev[0])) |=> delta[0];
  endproperty
  a_delta_chg: assert property (p_delta_chg) else $error("cts change lost"); // [R3]

  property p_ri_fall;
    @(posedge ref_clk_in) disable iff (reset_in)
      (eff_prev[2] && !eff_pin[2] && !delta[2]) |=> !delta[2];
  endproperty
  a_ri_fall: assert property (p_ri_fall) else $error("ring set on fall"); // [R4]

  property p_irq;
    @(posedge ref_clk_in) disable iff (reset_in)
      (delta_set[3] && interrupt_enable[IER_MSI] && !we_ier) |=> modem_irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("modem interrupt missing"); // [R5]

  property p_pause;
    @(posedge ref_clk_in) disable iff (reset_in)
      (enhanced_feature[EFR_ACTS] && !eff_pin[0]) |=> !tx_pause_out;
  endproperty
  a_pause: assert property (p_pause) else $error("pause with cts low"); // [R6]

  property p_loop;
    @(posedge ref_clk_in) disable iff (reset_in)
      (loop_en && msr_rd) |=> (data_out[7:4] == {modem_control[3], modem_control[2], modem_control[0], modem_control[1]});
  endproperty
  a_loop: assert property (p_loop) else $error("loopback status wrong"); // [R8]

  property p_dld_lock;
    @(posedge ref_clk_in) disable iff (reset_in)
      (we_dld && !enh_en) |=> $stable(divisor_fraction_sampling);
  endproperty
  a_dld_lock: assert property (p_dld_lock) else $error("locked fraction written"); // [R11]

  property p_srate;
    @(posedge ref_clk_in) disable iff (reset_in)
      (divisor_fraction_sampling[DLD_SR4] && !we_dld) |=> (divisor_out.srate == SR_4X);
  endproperty
  a_srate: assert property (p_srate) else $error("4x rate not selected"); // [R12]

  property p_dld_rsv;
    @(posedge ref_clk_in) disable iff (reset_in)
      we_dld |=> (divisor_fraction_sampling[7:6] == 2'h0);
  endproperty
  a_dld_rsv: assert property (p_dld_rsv) else $error("reserved bits set"); // [R21]
endmodule

// ==== verif/usf_host_model.sv ====
module usf_host_model (
  input  wire logic       ref_clk_in, // device clock
  input  wire logic [7:0] rd_data_in, // value the device drives
  input  wire logic       rd_oe_in,   // device drives the data bus
  output logic            cs_n_out,   // chip select, active low
  output logic            ior_n_out,  // read strobe, active low
  output logic            iow_n_out,  // write strobe, active low
  output logic [2:0]      addr_out,   // register address
  output logic [7:0]      data_out    // write data pins
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    cs_n_out = 1'b1;
    ior_n_out = 1'b1;
    iow_n_out = 1'b1;
    addr_out = 3'h0;
    data_out = 8'h00;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask

  // strobes stay low 4 cycles and address holds 4 more, above the 3-cycle minimum
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr_out = a;
    data_out = d;
    cs_n_out = 1'b0;
    iow_n_out = 1'b0;
    cyc(4);
    cs_n_out = 1'b1;
    iow_n_out = 1'b1;
    cyc(4);
    // a released bus must not keep showing the written byte
    data_out = ~d;
    cyc(2);
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    addr_out = a;
    cs_n_out = 1'b0;
    ior_n_out = 1'b0;
    cyc(5);
    d = rd_oe_in ? rd_data_in : 8'hxx;
    cs_n_out = 1'b1;
    ior_n_out = 1'b1;
    cyc(4);
  endtask
endmodule

// ==== verif/tb.sv ====
module tb
  import usf_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  logic       clk;
  logic       rst;
  logic       cs_n, ior_n, iow_n, doe, txf_e, txh_e, txs_e;
  logic       push, push_err, pop, pop_err, pause, irq;
  logic [2:0] addr;
  logic [7:0] pin_data, dout, rdv, interrupt_enable, modem_control, fifo_control;
  logic [5:0] lsr_low;
  usf_modem_t modem_n;
  usf_baud_t  baud;
  usf_flow_t  flow;
  int         n_mismatch = 0;
  int         n_compared = 0;
  int         cycles = 0;
  logic [7:0] fr [4] = '{8'h0a, 8'h1a, 8'h2a, 8'h3a};
  usf_srate_t sr [4] = '{SR_16X, SR_8X, SR_4X, SR_4X};

  always #2.5 clk = ~clk;

  usf_regs u_usf_regs (.ref_clk_in(clk), .reset_in(rst), .cs_n_in(cs_n), .ior_n_in(ior_n),
    .iow_n_in(iow_n), .addr_in(addr), .data_in(pin_data), .data_out(dout),
    .data_oe_out(doe), .modem_n_in(modem_n), .rx_data_in(8'h00), .isr_in(8'h00),
    .lsr_low_in(lsr_low), .tx_fifo_empty_in(txf_e), .tx_holding_empty_in(txh_e),
    .tx_shift_empty_in(txs_e), .rx_push_in(push), .rx_push_err_in(push_err),
    .rx_pop_in(pop), .rx_pop_err_in(pop_err), .divisor_out(baud), .flow_out(flow),
    .tx_pause_out(pause), .modem_irq_out(irq), .ier_out(interrupt_enable), .fcr_out(fifo_control), .lcr_out(),
    .mcr_out(modem_control), .thr_wr_out(), .fcr_wr_out(), .wr_data_out(), .rhr_rd_out());

  usf_host_model u_usf_host_model (.ref_clk_in(clk), .rd_data_in(dout), .rd_oe_in(doe),
    .cs_n_out(cs_n), .ior_n_out(ior_n), .iow_n_out(iow_n), .addr_out(addr),
    .data_out(pin_data));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic w(input logic [2:0] a, input logic [7:0] d);
    u_usf_host_model.wr(a, d);
  endtask

  task automatic rc(input string nm, input logic [2:0] a, input logic [7:0] exp,
                    input logic [7:0] m = 8'hff);
    u_usf_host_model.rd(a, rdv);
    chk(nm, exp, rdv & m);
  endtask

  task automatic tag_pulse(input logic is_push);
    push = is_push;
    push_err = is_push;
    pop = !is_push;
    pop_err = !is_push;
    cyc(1);
    {push, push_err, pop, pop_err} = 4'h0;
    cyc(1);
  endtask

  // expected flow modes worked out from the four select bits
  function automatic logic [7:0] flow_exp(input logic [3:0] v);
    usf_flow_t e;
    case (v[3:2])
      2'b10: e.tx_mode = TXF_PAIR1;
      2'b01: e.tx_mode = TXF_PAIR2;
      2'b11: e.tx_mode = TXF_DUAL;
      default: e.tx_mode = TXF_NONE;
    endcase
    case (v[1:0])
      2'b10: e.rx_mode = RXF_PAIR1;
      2'b01: e.rx_mode = RXF_PAIR2;
      2'b11: e.rx_mode = (v[3] ^ v[2]) ? RXF_EITHER : RXF_DUAL;
      default: e.rx_mode = RXF_NONE;
    endcase
    e.tx_dual = &v[3:2];
    e.rx_dual = (e.rx_mode == RXF_DUAL);
    return {1'b0, e};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    modem_n = PINS_IDLE;
    lsr_low = 6'h21;
    {txf_e, txh_e, txs_e} = 3'h7;
    {push, push_err, pop, pop_err} = 4'h0;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    rc("line status", OFS_LSR, 8'h61);
    rc("scratch", OFS_SPR, 8'hff);
    w(OFS_SPR, 8'h5a);
    rc("scratch", OFS_SPR, 8'h5a);
    txs_e = 1'b0;
    rc("line status", OFS_LSR, 8'h21);
    txs_e = 1'b1;
    txh_e = 1'b0;
    rc("line status", OFS_LSR, 8'h21);
    txh_e = 1'b1;
    w(OFS_FCR, 8'h31);
    chk("fifo control", 8'h01, fifo_control);
    txf_e = 1'b0;
    rc("line status", OFS_LSR, 8'h21);
    txf_e = 1'b1;
    rc("line status", OFS_LSR, 8'h61);
    tag_pulse(1'b1);
    tag_pulse(1'b1);
    tag_pulse(1'b0);
    rc("line status", OFS_LSR, 8'he1);
    tag_pulse(1'b0);
    rc("line status", OFS_LSR, 8'h61);
    // modem pins, with the modem interrupt enabled
    w(OFS_IER, 8'h08);
    chk("modem irq", 8'h00, {7'h0, irq});
    modem_n = 4'he;
    cyc(5);
    chk("modem irq", 8'h01, {7'h0, irq});
    rc("modem status", OFS_MSR, 8'h11);
    chk("modem irq", 8'h00, {7'h0, irq});
    modem_n = 4'ha;
    cyc(5);
    rc("modem status", OFS_MSR, 8'h50);
    modem_n = 4'he;
    cyc(5);
    rc("modem status", OFS_MSR, 8'h14);
    modem_n = 4'h4;
    cyc(5);
    rc("modem status", OFS_MSR, 8'hba);
    modem_n = PINS_IDLE;
    cyc(5);
    rc("modem status", OFS_MSR, 8'h0b);
    // enhanced bits locked while the enable is clear
    w(OFS_IER, 8'hff);
    chk("interrupt enable", 8'h0f, interrupt_enable);
    w(OFS_MCR, 8'hf5);
    chk("modem control", 8'h15, modem_control);
    rc("modem status", OFS_MSR, 8'h60, 8'hf0);
    w(OFS_MCR, 8'h00);
    w(OFS_LCR, 8'h80);
    w(OFS_DLD, 8'hff);
    rc("fraction", OFS_DLD, 8'h00);
    w(OFS_LCR, LCR_EFR_KEY);
    w(OFS_EFR, 8'h10);
    w(OFS_LCR, 8'h80);
    w(OFS_DLD, 8'hff);
    rc("fraction", OFS_DLD, 8'h3f);
    for (int i = 0; i < 4; i++) begin
      w(OFS_DLD, fr[i]);
      chk("fraction part", 8'h0a, {4'h0, baud.fraction});
      chk("sampling rate", {6'h0, sr[i]}, {6'h0, baud.srate});
    end
    w(OFS_DLL, 8'h34);
    w(OFS_DLM, 8'h12);
    chk("divisor low", 8'h34, baud.integer_part[7:0]);
    chk("divisor high", 8'h12, baud.integer_part[15:8]);
    w(OFS_LCR, 8'h00);
    w(OFS_IER, 8'hf0);
    chk("interrupt enable", 8'hf0, interrupt_enable);
    w(OFS_FCR, 8'h31);
    chk("fifo control", 8'h31, fifo_control);
    w(OFS_MCR, 8'h80);
    chk("prescale", 8'h01, {7'h0, baud.prescale4});
    w(OFS_LCR, LCR_EFR_KEY);
    for (int v = 0; v < 16; v++) begin
      w(OFS_EFR, 8'h10);
      w(OFS_EFR, {4'h1, v[3:0]});
      chk("flow modes", flow_exp(v[3:0]), {1'b0, flow});
    end
    // cts pin is high here, so auto cts must hold the transmitter
    w(OFS_EFR, 8'h90);
    chk("tx pause", 8'h01, {7'h0, pause});
    modem_n = 4'he;
    cyc(6);
    chk("tx pause", 8'h00, {7'h0, pause});
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    chk("interrupt enable", 8'h00, interrupt_enable);
    chk("modem control", 8'h00, modem_control);
    rc("scratch", OFS_SPR, 8'hff);
    chk("divisor low", 8'h01, baud.integer_part[7:0]);
    rc("modem status", OFS_MSR, 8'h10);
    w(OFS_LCR, LCR_EFR_KEY);
    rc("feature", OFS_EFR, 8'h00);
    w(OFS_LCR, 8'h80);
    rc("fraction", OFS_DLD, 8'h00);
    final_report();
  end
endmodule
